/* logic/deeac_pkg.sv */
// package: register map, field layout and timing for the data eeprom access controller
package deeac_pkg;
  // register offsets in the special-function space
  localparam logic [7:0] REG_BYTE_DATA = 8'h08;
  localparam logic [7:0] REG_CELL_INDEX = 8'h09;
  localparam logic [7:0] REG_CONTROL = 8'h88;
  localparam logic [7:0] REG_UNLOCK = 8'h89;
  // control register fields
  localparam int FETCH_BIT = 0;
  localparam int PROGRAM_BIT = 1;
  localparam int PERMIT_BIT = 2;
  localparam int ABORT_BIT = 3;
  localparam int DONE_BIT = 4;
  localparam logic [7:0] CONTROL_IMPL_MASK = 8'h1f;
  // unlock sequence values
  localparam logic [7:0] UNLOCK_FIRST = 8'h55;
  localparam logic [7:0] UNLOCK_SECOND = 8'haa;
  // array geometry
  localparam int CELL_COUNT = 64;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // nominal write time and its cycle count at 50 mhz
  localparam int WRITE_TIME_US = 10000;
  localparam int CLK_MHZ = 50;
  localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
  // special-function register access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } deeac_sfr_req_t;
  // reset causes
  typedef struct packed {
    logic power_on;
    logic ext_pin;
    logic watchdog;
  } deeac_rst_cause_t;
endpackage

/* logic/deeac_ctrl.sv */
// data eeprom access controller: sfr registers, unlock sequence, timed write and read
`timescale 1ns/1ns
`default_nettype none

// Operation
// RULE1: sixty-four byte cells at addresses 00h to 3Fh, individually readable and writable
// RULE2: eight-bit data register holds read result and byte to store
// RULE3: index register is eight bits; upper two bits must be zero to hit a cell; the code ignores bits 7:6 and selects with bits 5:0
// RULE4: each write erases the cell then programs the new byte
// RULE5: write duration set by internal timer; completion only at expiry
// RULE6: under code protection core access works, programmer access is blocked
// RULE7: control bits 7:5 absent and read zero
// RULE8: done flag bit 4 set at write end; only software clears it
// RULE9: abort flag bit 3 set when pin or watchdog reset cuts a write
// RULE10: data and index registers survive the reset that aborted a write
// RULE11: permit bit 2 enables writes; cleared on power-up
// RULE12: program and fetch triggers settable only; hardware clears them at completion
// RULE13: after fetch trigger the addressed byte sits in data register next cycle
// RULE14: data register holds until next read or software write
// RULE15: unlock port has no storage and reads zero
// RULE16: write starts only after 55h then AAh to unlock port then trigger
// RULE17: program trigger ignored while permit is zero
// RULE18: started write completes even if permit is cleared
// RULE19: completion clears program trigger and sets done flag together
// RULE20: write timer terminal count is a module parameter
module deeac_ctrl
  import deeac_pkg::*;
#(
  parameter int CELLS = CELL_COUNT,
  parameter int WRITE_CNT = WRITE_CYCLES
) (
  // clock and resets
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire deeac_rst_cause_t rst_cause_i,
  // core sfr port
  input wire deeac_sfr_req_t sfr_req_i,
  output logic [7:0] sfr_rdata_o,
  // external programmer port
  input wire logic code_protect_i,
  input wire logic prog_rd_i,
  input wire logic prog_wr_i,
  input wire logic [5:0] prog_addr_i,
  input wire logic [7:0] prog_wdata_i,
  output logic [7:0] prog_rdata_o,
  output logic prog_blocked_o,
  // status
  output logic write_busy_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    UNL_IDLE,
    UNL_FIRST,
    UNL_ARMED
  } deeac_unlock_t;

  logic [7:0] cell_mem_reg [CELLS];
  logic [7:0] cell_mem_next [CELLS];
  logic [7:0] rom_byte_reg, rom_byte_next;
  logic [7:0] cell_index_reg, cell_index_next;
  logic store_done_flag_reg, store_done_flag_next;
  logic store_abort_flag_reg, store_abort_flag_next;
  logic store_permit_reg, store_permit_next;
  logic program_trigger_reg, program_trigger_next;
  logic fetch_trigger_reg, fetch_trigger_next;
  logic [31:0] timer_reg, timer_next;
  logic erased_reg, erased_next;
  logic [7:0] sfr_rdata_reg, sfr_rdata_next;
  logic [7:0] prog_rdata_reg, prog_rdata_next;
  logic prog_blocked_reg, prog_blocked_next;
  logic run_track_reg, run_track_next;
  deeac_unlock_t unlock_reg, unlock_next;

  logic [5:0] cell_sel;
  logic [7:0] control_view;
  logic core_wr, timer_end;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  assign cell_sel = cell_index_reg[5:0]; // RULE1 RULE3
  assign core_wr = sfr_req_i.wr;
  assign timer_end = program_trigger_reg && (timer_reg == 32'(WRITE_CNT - 1)); // RULE5 RULE20
  assign control_view = {3'b000, store_done_flag_reg, store_abort_flag_reg, // RULE7
    store_permit_reg, program_trigger_reg, fetch_trigger_reg};

  // ---------------------------------------------------------------
  // next-state
  // ---------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < CELLS; i++) begin
      cell_mem_next[i] = cell_mem_reg[i];
    end
    rom_byte_next = rom_byte_reg;
    cell_index_next = cell_index_reg;
    store_done_flag_next = store_done_flag_reg;
    store_abort_flag_next = store_abort_flag_reg;
    store_permit_next = store_permit_reg;
    program_trigger_next = program_trigger_reg;
    fetch_trigger_next = 1'b0; // RULE12
    timer_next = timer_reg;
    erased_next = erased_reg;
    unlock_next = unlock_reg;
    sfr_rdata_next = 8'h00;
    prog_rdata_next = prog_rdata_reg;
    prog_blocked_next = 1'b0;

    // read: one-cycle fetch into the data register
    if (fetch_trigger_reg) begin
      rom_byte_next = cell_mem_reg[cell_sel]; // RULE13 RULE14
    end

    // timed write: erase on entry, program at expiry
    if (program_trigger_reg) begin
      if (!erased_reg) begin
        cell_mem_next[cell_sel] = 8'hff; // RULE4
        erased_next = 1'b1;
      end
      if (timer_end) begin
        cell_mem_next[cell_sel] = rom_byte_reg; // RULE4 RULE5
        program_trigger_next = 1'b0; // RULE19 RULE12
        store_done_flag_next = 1'b1; // RULE19 RULE8
        store_abort_flag_next = 1'b0;
        timer_next = 32'h0000_0000;
        erased_next = 1'b0;
      end else begin
        timer_next = timer_reg + 32'h0000_0001;
      end
    end

    // core register writes
    if (core_wr) begin
      unique case (sfr_req_i.addr)
        REG_BYTE_DATA: begin
          if (!program_trigger_reg) begin
            rom_byte_next = sfr_req_i.wdata; // RULE2 RULE14
          end
        end
        REG_CELL_INDEX: begin
          if (!program_trigger_reg) begin
            cell_index_next = sfr_req_i.wdata; // RULE3
          end
        end
        REG_CONTROL: begin
          store_permit_next = sfr_req_i.wdata[PERMIT_BIT]; // RULE11 RULE18
          // software may clear the flags, hardware set wins
          if (!timer_end) begin
            store_done_flag_next = sfr_req_i.wdata[DONE_BIT]; // RULE8
          end
          store_abort_flag_next = sfr_req_i.wdata[ABORT_BIT];
          if (sfr_req_i.wdata[FETCH_BIT] && !program_trigger_reg) begin
            fetch_trigger_next = 1'b1; // RULE12 RULE13
          end
          if (sfr_req_i.wdata[PROGRAM_BIT] && unlock_reg == UNL_ARMED
              && store_permit_reg && !program_trigger_reg) begin // RULE16 RULE17
            program_trigger_next = 1'b1;
            timer_next = 32'h0000_0000;
            erased_next = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // write-running copy that the async reset cannot wipe
    run_track_next = program_trigger_next; // RULE9

    // unlock sequence: any other core write breaks it, except a repeated 55h, which keeps it at the first step
    if (core_wr) begin
      case (unlock_reg)
        UNL_IDLE: begin
          if (sfr_req_i.addr == REG_UNLOCK && sfr_req_i.wdata == UNLOCK_FIRST) begin
            unlock_next = UNL_FIRST; // RULE16
          end
        end
        UNL_FIRST: begin
          if (sfr_req_i.addr == REG_UNLOCK && sfr_req_i.wdata == UNLOCK_SECOND) begin
            unlock_next = UNL_ARMED; // RULE16
          end else if (sfr_req_i.addr == REG_UNLOCK && sfr_req_i.wdata == UNLOCK_FIRST) begin
            unlock_next = UNL_FIRST;
          end else begin
            unlock_next = UNL_IDLE;
          end
        end
        UNL_ARMED: begin
          unlock_next = UNL_IDLE; // RULE16
        end
        default: begin
          unlock_next = UNL_IDLE;
        end
      endcase
    end

    // core register reads, answered next cycle
    if (sfr_req_i.rd) begin
      case (sfr_req_i.addr)
        REG_BYTE_DATA: sfr_rdata_next = rom_byte_reg;
        REG_CELL_INDEX: sfr_rdata_next = cell_index_reg;
        REG_CONTROL: sfr_rdata_next = control_view & CONTROL_IMPL_MASK; // RULE7
        REG_UNLOCK: sfr_rdata_next = 8'h00; // RULE15
        default: sfr_rdata_next = 8'h00;
      endcase
    end

    // external programmer, locked out under code protection
    if (prog_rd_i || prog_wr_i) begin
      if (code_protect_i) begin
        prog_blocked_next = 1'b1; // RULE6
        if (prog_rd_i) begin
          prog_rdata_next = 8'h00;
        end
      end else if (prog_wr_i && !program_trigger_reg) begin
        cell_mem_next[prog_addr_i] = prog_wdata_i;
      end else if (prog_rd_i) begin
        prog_rdata_next = cell_mem_reg[prog_addr_i];
      end
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // cells keep their value across all resets; data/index are cleared by power-on
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < CELLS; i++) begin
      cell_mem_reg[i] <= cell_mem_next[i]; // RULE1
    end
  end

  // data and index: reset only by power-on, kept after pin or watchdog reset
  always_ff @(posedge clk_i) begin
    if (rst_cause_i.power_on) begin
      rom_byte_reg <= RESET_BYTE;
      cell_index_reg <= RESET_BYTE;
    end else if (!sys_rst_i) begin
      rom_byte_reg <= rom_byte_next; // RULE10
      cell_index_reg <= cell_index_next; // RULE10
    end
  end

  // write-running tracker: holds its last value into the first reset edge
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      run_track_reg <= 1'b0;
    end else begin
      run_track_reg <= run_track_next;
    end
  end

  // abort flag: set when a pin or watchdog reset lands during a write
  always_ff @(posedge clk_i) begin
    if (rst_cause_i.power_on) begin
      store_abort_flag_reg <= 1'b0;
    end else if (sys_rst_i) begin
      if (run_track_reg && (rst_cause_i.ext_pin || rst_cause_i.watchdog)) begin
        store_abort_flag_reg <= 1'b1; // RULE9
      end
    end else begin
      store_abort_flag_reg <= store_abort_flag_next;
    end
  end

  // done flag survives non-power resets
  always_ff @(posedge clk_i) begin
    if (rst_cause_i.power_on) begin
      store_done_flag_reg <= 1'b0;
    end else if (!sys_rst_i) begin
      store_done_flag_reg <= store_done_flag_next; // RULE8
    end
  end

  // control state cleared by any reset
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      store_permit_reg <= 1'b0; // RULE11
      program_trigger_reg <= 1'b0;
      fetch_trigger_reg <= 1'b0;
      timer_reg <= 32'h0000_0000;
      erased_reg <= 1'b0;
      unlock_reg <= UNL_IDLE;
      sfr_rdata_reg <= 8'h00;
      prog_rdata_reg <= 8'h00;
      prog_blocked_reg <= 1'b0;
    end else begin
      store_permit_reg <= store_permit_next;
      program_trigger_reg <= program_trigger_next;
      fetch_trigger_reg <= fetch_trigger_next;
      timer_reg <= timer_next;
      erased_reg <= erased_next;
      unlock_reg <= unlock_next;
      sfr_rdata_reg <= sfr_rdata_next;
      prog_rdata_reg <= prog_rdata_next;
      prog_blocked_reg <= prog_blocked_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign sfr_rdata_o = sfr_rdata_reg;
  assign prog_rdata_o = prog_rdata_reg;
  assign prog_blocked_o = prog_blocked_reg;
  assign write_busy_o = program_trigger_reg;

endmodule

`default_nettype wire

/* bench/deeac_ctrl_asserts.sv */
// checker: port properties of the eeprom access controller
`timescale 1ns/1ns
`default_nettype none
module deeac_ctrl_asserts
  import deeac_pkg::*;
#(
  parameter int CELLS = CELL_COUNT,
  parameter int WRITE_CNT = WRITE_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // core port
  input wire deeac_sfr_req_t sfr_req_i,
  input wire logic [7:0] sfr_rdata_o,
  // programmer port and status
  input wire logic code_protect_i,
  input wire logic prog_rd_i,
  input wire logic prog_wr_i,
  input wire logic [7:0] prog_rdata_o,
  input wire logic prog_blocked_o,
  input wire logic write_busy_o
);
  logic [31:0] busy_cnt_reg;
  logic [31:0] busy_cnt_next;
  logic rd_ctl;
  logic trig;
  logic ul_a;
  logic ul_b;
  assign rd_ctl = sfr_req_i.rd && sfr_req_i.addr == REG_CONTROL;
  assign trig = sfr_req_i.wr && sfr_req_i.addr == REG_CONTROL && sfr_req_i.wdata[PROGRAM_BIT];
  assign ul_a = sfr_req_i.wr && sfr_req_i.addr == REG_UNLOCK && sfr_req_i.wdata == UNLOCK_FIRST;
  assign ul_b = sfr_req_i.wr && sfr_req_i.addr == REG_UNLOCK && sfr_req_i.wdata == UNLOCK_SECOND;
  // counts cycles of a running write
  always_comb busy_cnt_next = write_busy_o ? busy_cnt_reg + 32'h1 : 32'h0;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) busy_cnt_reg <= 32'h0;
    else busy_cnt_reg <= busy_cnt_next;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  ctl_upper_a: assert property (rd_ctl |=> sfr_rdata_o[7:5] == 3'h0)
    else $error("control upper bits not zero");
  unlock_zero_a: assert property (sfr_req_i.rd && sfr_req_i.addr == REG_UNLOCK |=>
    sfr_rdata_o == 8'h00) else $error("unlock port read not zero");
  busy_bit_a: assert property (rd_ctl |=> sfr_rdata_o[PROGRAM_BIT] == $past(write_busy_o))
    else $error("program bit differs from busy");
  start_seq_a: assert property ($rose(write_busy_o) |->
    $past(trig) && $past(ul_b, 2) && $past(ul_a, 3)) else $error("write began without unlock");
  busy_max_a: assert property (write_busy_o |-> busy_cnt_reg < WRITE_CNT)
    else $error("write cycle too long");
  busy_min_a: assert property ($fell(write_busy_o) |-> busy_cnt_reg == WRITE_CNT)
    else $error("write cycle too short");
  prog_block_a: assert property (prog_rd_i || prog_wr_i |=>
    prog_blocked_o == $past(code_protect_i)) else $error("programmer refusal wrong");
  prog_hold_a: assert property (!prog_rd_i |=> $stable(prog_rdata_o))
    else $error("programmer read data changed");
  cover property ($rose(write_busy_o));
  cover property (prog_blocked_o);
  cover property (rd_ctl ##1 sfr_rdata_o[ABORT_BIT]);
endmodule
bind deeac_ctrl deeac_ctrl_asserts #(.CELLS(CELLS), .WRITE_CNT(WRITE_CNT)) chk_i (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .sfr_req_i(sfr_req_i), .sfr_rdata_o(sfr_rdata_o),
  .code_protect_i(code_protect_i), .prog_rd_i(prog_rd_i), .prog_wr_i(prog_wr_i),
  .prog_rdata_o(prog_rdata_o), .prog_blocked_o(prog_blocked_o), .write_busy_o(write_busy_o));
`default_nettype wire

/* bench/deeac_core_model.sv */
// core model: issues register accesses to the controller
`timescale 1ns/1ns
`default_nettype none
module deeac_core_model
  import deeac_pkg::*;
(
  // clock and read return
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  // request
  output var deeac_sfr_req_t req_o
);
  initial req_o = '0;
  // request held over one edge, read data taken just after it
  task automatic access(input logic w, input logic r, input logic [7:0] a,
                        input logic [7:0] d, output logic [7:0] q);
    req_o = '{wr: w, rd: r, addr: a, wdata: d};
    @(posedge clk_i);
    #1;
    q = rdata_i;
  endtask
endmodule
`default_nettype wire

/* bench/deeac_ctrl_bench.sv */
// testbench: scenarios for the eeprom access controller
`timescale 1ns/1ns
`default_nettype none
module deeac_ctrl_bench;
  import deeac_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  deeac_rst_cause_t rst_cause_i = 3'h4;
  wire deeac_sfr_req_t sfr_req_i;
  logic [7:0] sfr_rdata_o;
  logic [7:0] prog_rdata_o;
  logic [7:0] q;
  logic code_protect_i = 1'b0;
  logic prog_rd_i = 1'b0;
  logic prog_wr_i = 1'b0;
  logic [5:0] prog_addr_i = 6'h00;
  logic [7:0] prog_wdata_i = 8'h00;
  logic prog_blocked_o;
  logic write_busy_o;
  int errors = 0;
  int comparisons = 0;
  always #10 clk_i = ~clk_i;
  deeac_ctrl #(.WRITE_CNT(8)) uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .rst_cause_i(rst_cause_i), .sfr_req_i(sfr_req_i), .sfr_rdata_o(sfr_rdata_o),
    .code_protect_i(code_protect_i), .prog_rd_i(prog_rd_i), .prog_wr_i(prog_wr_i),
    .prog_addr_i(prog_addr_i), .prog_wdata_i(prog_wdata_i), .prog_rdata_o(prog_rdata_o),
    .prog_blocked_o(prog_blocked_o), .write_busy_o(write_busy_o));
  deeac_core_model core (.clk_i(clk_i), .rdata_i(sfr_rdata_o), .req_o(sfr_req_i));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    core.access(1'b1, 1'b0, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a);
    core.access(1'b0, 1'b1, a, 8'h00, q);
  endtask
  task automatic idle();
    core.access(1'b0, 1'b0, 8'h00, 8'h00, q);
  endtask
  task automatic start_write(input logic [7:0] a, input logic [7:0] d);
    wr(REG_CELL_INDEX, a);
    wr(REG_BYTE_DATA, d);
    wr(REG_CONTROL, 8'h04);
    wr(REG_UNLOCK, UNLOCK_FIRST);
    wr(REG_UNLOCK, UNLOCK_SECOND);
    wr(REG_CONTROL, 8'h06);
    idle();
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (write_busy_o !== 1'b0 && n < 40) begin
      idle();
      n++;
    end
    chk({7'h00, write_busy_o}, 8'h00);
  endtask
  task automatic fetch_chk(input logic [7:0] a, input logic [7:0] exp);
    wr(REG_CELL_INDEX, a);
    wr(REG_CONTROL, 8'h01);
    idle();
    rd(REG_BYTE_DATA);
    chk(q, exp);
    idle();
  endtask
  task automatic prog_acc(input logic w, input logic [5:0] a, input logic [7:0] blk);
    @(posedge clk_i);
    #1;
    {prog_wr_i, prog_rd_i, prog_addr_i} = {w, ~w, a};
    @(posedge clk_i);
    #1;
    {prog_wr_i, prog_rd_i} = 2'h0;
    chk({7'h00, prog_blocked_o}, blk);
  endtask
  task automatic t_writes();
    start_write(8'h00, 8'ha5);
    chk({7'h00, write_busy_o}, 8'h01);
    prog_acc(1'b0, 6'h00, 8'h00);
    chk(prog_rdata_o, 8'hff);
    wait_idle();
    rd(REG_CONTROL);
    chk(q, 8'h14);
    fetch_chk(8'h00, 8'ha5);
    start_write(8'h3f, 8'h5a);
    wr(REG_CONTROL, 8'h00);
    idle();
    chk({7'h00, write_busy_o}, 8'h01);
    wait_idle();
    fetch_chk(8'h3f, 8'h5a);
    $display("write test done");
  endtask
  task automatic t_refuse();
    wr(REG_BYTE_DATA, 8'h99);
    wr(REG_UNLOCK, UNLOCK_FIRST);
    wr(REG_UNLOCK, UNLOCK_SECOND);
    wr(REG_CONTROL, 8'h02);
    idle();
    chk({7'h00, write_busy_o}, 8'h00);
    wr(REG_CONTROL, 8'h04);
    wr(REG_UNLOCK, UNLOCK_SECOND);
    wr(REG_UNLOCK, UNLOCK_FIRST);
    wr(REG_CONTROL, 8'h06);
    idle();
    chk({7'h00, write_busy_o}, 8'h00);
    wr(REG_CONTROL, 8'hff);
    idle();
    rd(REG_CONTROL);
    chk(q, 8'h1c);
    rd(REG_UNLOCK);
    chk(q, 8'h00);
    fetch_chk(8'h00, 8'ha5);
    $display("refusal test done");
  endtask
  task automatic cut_reset(input logic [3:0] v);
    {sys_rst_i, rst_cause_i} = v;
    repeat (2) @(posedge clk_i);
    #1;
    {sys_rst_i, rst_cause_i} = 4'h0;
  endtask
  task automatic t_abort();
    start_write(8'h20, 8'h77);
    cut_reset(4'ha);
    rd(REG_CONTROL);
    chk(q, 8'h08);
    rd(REG_BYTE_DATA);
    chk(q, 8'h77);
    rd(REG_CELL_INDEX);
    chk(q, 8'h20);
    start_write(8'h20, 8'h77);
    wait_idle();
    rd(REG_BYTE_DATA);
    chk(q, 8'h77);
    rd(REG_CONTROL);
    chk(q, 8'h14);
    idle();
    start_write(8'h21, 8'h66);
    cut_reset(4'h9);
    rd(REG_CONTROL);
    chk(q, 8'h08);
    rd(REG_BYTE_DATA);
    chk(q, 8'h66);
    idle();
    $display("abort test done");
  endtask
  task automatic t_protect();
    code_protect_i = 1'b1;
    prog_acc(1'b0, 6'h00, 8'h01);
    prog_acc(1'b1, 6'h00, 8'h01);
    fetch_chk(8'h20, 8'h77);
    code_protect_i = 1'b0;
    prog_acc(1'b0, 6'h3f, 8'h00);
    chk(prog_rdata_o, 8'h5a);
    prog_acc(1'b0, 6'h00, 8'h00);
    chk(prog_rdata_o, 8'ha5);
    prog_wdata_i = 8'h3c;
    prog_acc(1'b1, 6'h10, 8'h00);
    fetch_chk(8'h10, 8'h3c);
    $display("protect test done");
  endtask
  task automatic summarize();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #40000;
    errors++;
    summarize();
  end
  initial begin
    repeat (12) @(posedge clk_i);
    #1;
    {sys_rst_i, rst_cause_i} = 4'h0;
    rd(REG_CONTROL);
    chk(q, 8'h00);
    rd(REG_BYTE_DATA);
    chk(q, 8'h00);
    idle();
    t_writes();
    t_refuse();
    t_abort();
    t_protect();
    summarize();
  end
endmodule
`default_nettype wire
